// ===== umb_pointers.v
/*
  Pointer, queue-select and status logic for the transmit and receive
  message buffers of a serial-host to UART bridge.
  Assumes an upstream serial front end that delivers a command pulse with
  the command address, then one pulse per burst data byte, all on CLK, and
  UART logic on the same clock that stores received bytes and reports the
  queue it is sending from.
  Each advance starts the byte pointer at location zero; the command
  byte picks no other start location.
*/
`default_nettype none
`include "umb_consts.vh"

module umb_pointers #(
  parameter AW = 7
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Host register transactions
  input wire HOST_CMD,
  input wire [7:0] HOST_ADDR,
  input wire HOST_WR,
  input wire [7:0] HOST_WDATA,
  input wire HOST_RD,
  output wire [7:0] HOST_RDATA,
  // UART receive side
  input wire UART_WR,
  input wire [7:0] UART_DATA,
  input wire UART_FIRST,
  input wire UART_ERR,
  input wire UART_LAST,
  output wire UART_WR_READY,
  // UART transmit side
  input wire [1:0] UART_SEND_QUEUE,
  // Transmit load queue write strobe
  output wire TXQ_WR_EN,
  output wire [1:0] TXQ_WR_QUEUE,
  output wire [4:0] TXQ_WR_LOC,
  output wire [7:0] TXQ_WR_DATA
);

  localparam DW = 11;

  // Register select codes
  localparam SEL_NONE = 4'h0;
  localparam SEL_TXQ = 4'h1;
  localparam SEL_RD = 4'h2;
  localparam SEL_WR = 4'h3;
  localparam SEL_NXT = 4'h4;
  localparam SEL_SPACE = 4'h5;
  localparam SEL_FLAGS = 4'h6;
  localparam SEL_ADV = 4'h7;
  localparam SEL_MSG = 4'h8;
  localparam SEL_NMSG = 4'h9;

  // Maps an address, either direction, to a register select code
  function [3:0] reg_sel;
    input [7:0] addr;
    reg [7:0] a;
    begin
      a = {addr[7:1], 1'b0};
      case (a)
        `UMB_OFS_TXQ_SEL: reg_sel = SEL_TXQ;
        `UMB_OFS_RD_POINTER: reg_sel = SEL_RD;
        `UMB_OFS_WR_POINTER: reg_sel = SEL_WR;
        `UMB_OFS_RX_NXT_PTR: reg_sel = SEL_NXT;
        `UMB_OFS_FREE_SPACE: reg_sel = SEL_SPACE;
        `UMB_OFS_RX_FLAGS: reg_sel = SEL_FLAGS;
        `UMB_OFS_ADV_LOAD: reg_sel = SEL_ADV;
        `UMB_OFS_RX_MSG: reg_sel = SEL_MSG;
        `UMB_OFS_RX_NXT_MSG: reg_sel = SEL_NMSG;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // State registers
  reg [7:0] cmd_addr_q;
  reg [7:0] cmd_addr_d;
  reg [1:0] send_queue_q;
  reg [1:0] filling_queue_index_q;
  reg [1:0] filling_queue_index_d;
  reg [4:0] queue_byte_pointer_q;
  reg [4:0] queue_byte_pointer_d;
  reg [AW-1:0] receive_read_pointer_q;
  reg [AW-1:0] receive_read_pointer_d;
  reg [AW-1:0] receive_write_pointer_q;
  reg [AW-1:0] receive_write_pointer_d;
  reg [AW-1:0] oldest_unread_message_pointer_q;
  reg [AW-1:0] oldest_unread_message_pointer_d;
  reg [6:0] free_space_q;
  reg [6:0] free_space_d;
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;
  reg txq_wr_en_q;
  reg txq_wr_en_d;
  reg [1:0] txq_wr_queue_q;
  reg [4:0] txq_wr_loc_q;
  reg [4:0] txq_wr_loc_d;
  reg [7:0] txq_wr_data_q;
  reg [7:0] txq_wr_data_d;

  // Combinational helpers
  wire [3:0] cmd_sel;
  wire [3:0] held_sel;
  wire store;
  wire [DW-1:0] entry;
  wire entry_last;
  wire rx_empty;
  wire msg_read;
  wire release_msg;
  wire [AW-1:0] release_len;
  wire [AW-1:0] rd_ptr_inc;

  assign cmd_sel = reg_sel(HOST_ADDR);
  assign held_sel = reg_sel(cmd_addr_q);

  // Receive store accepted only while space remains
  assign UART_WR_READY = (free_space_q != 7'h00);
  assign store = UART_WR && UART_WR_READY;

  umb_rx_store #(
    .AW(AW),
    .DW(DW)
  ) umb_rx_store_inst (
    .clk(CLK),
    .rst(RST),
    .wr_en(store),
    .wr_addr(receive_write_pointer_q),
    .wr_data({UART_FIRST, UART_ERR, UART_LAST, UART_DATA}),
    .rd_addr(receive_read_pointer_q),
    .rd_data(entry)
  );

  assign entry_last = entry[8 + `UMB_FLAG_LAST];
  assign rx_empty = (receive_read_pointer_q == receive_write_pointer_q);
  assign rd_ptr_inc = receive_read_pointer_q + {{(AW-1){1'b0}}, 1'b1};

  // A data read at either message port
  // Flag reads leave the read pointer where it is
  assign msg_read = HOST_RD && ((held_sel == SEL_MSG) || (held_sel == SEL_NMSG));

  // Reading a stop entry frees the whole message once
  assign release_msg = msg_read && !rx_empty && entry_last &&
                       (oldest_unread_message_pointer_q != rd_ptr_inc);
  assign release_len = rd_ptr_inc - oldest_unread_message_pointer_q;

  // Held command address; bursts never move it
  // Read commands load it too, so data reads follow them
  always @* begin
    cmd_addr_d = cmd_addr_q;
    if (HOST_CMD) begin
      cmd_addr_d = HOST_ADDR;
    end
  end

  // Transmit load queue selection and byte pointer
  always @* begin
    filling_queue_index_d = filling_queue_index_q;
    queue_byte_pointer_d = queue_byte_pointer_q;
    txq_wr_en_d = 1'b0;
    txq_wr_loc_d = txq_wr_loc_q;
    txq_wr_data_d = txq_wr_data_q;
    if (HOST_CMD && (cmd_sel == SEL_ADV) && !HOST_ADDR[0]) begin
      filling_queue_index_d = filling_queue_index_q + 2'h1;
      queue_byte_pointer_d = `UMB_LOC_ZERO;
    end else if (HOST_WR && (held_sel == SEL_ADV)) begin
      // drop bytes past location 30
      // Pointer parks at 31, so later bytes stay dropped
      if (queue_byte_pointer_q <= `UMB_LOC_LAST) begin
        txq_wr_en_d = 1'b1;
        txq_wr_loc_d = queue_byte_pointer_q;
        txq_wr_data_d = HOST_WDATA;
        queue_byte_pointer_d = queue_byte_pointer_q + 5'h01;
      end
    end
  end

  // Receive pointers and free space
  always @* begin
    receive_read_pointer_d = receive_read_pointer_q;
    receive_write_pointer_d = receive_write_pointer_q;
    oldest_unread_message_pointer_d = oldest_unread_message_pointer_q;
    free_space_d = free_space_q;
    // write pointer steps per stored byte
    if (store) begin
      receive_write_pointer_d = receive_write_pointer_q + {{(AW-1){1'b0}}, 1'b1};
    end
    if (HOST_CMD && (cmd_sel == SEL_NMSG)) begin
      receive_read_pointer_d = oldest_unread_message_pointer_q;
    end else if (msg_read && !rx_empty && !entry_last) begin
      receive_read_pointer_d = rd_ptr_inc;
    end
    // next message starts after the stop entry
    if (release_msg) begin
      oldest_unread_message_pointer_d = rd_ptr_inc;
    end
    // Store and release in one cycle both count; the ready gate
    // keeps the count from wrapping below zero
    // stores take space, releases return it
    free_space_d = free_space_q - {6'h00, store} +
                   (release_msg ? release_len[6:0] : 7'h00);
  end

  // Read data mux, captured on each host read
  always @* begin
    rdata_d = rdata_q;
    if (HOST_RD) begin
      case (held_sel)
        SEL_TXQ: rdata_d = {4'h0, send_queue_q, filling_queue_index_q};
        SEL_RD: rdata_d = {1'b0, receive_read_pointer_q};
        SEL_WR: rdata_d = {1'b0, receive_write_pointer_q};
        SEL_NXT: rdata_d = {1'b0, oldest_unread_message_pointer_q};
        SEL_SPACE: rdata_d = {1'b0, free_space_q};
        SEL_FLAGS: rdata_d = {5'h00, entry[10:8]};
        SEL_MSG: rdata_d = entry[7:0];
        SEL_NMSG: rdata_d = entry[7:0];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // All state flip-flops
  // UART queue index is on CLK already; one register aligns it
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      cmd_addr_q <= 8'h00;
      send_queue_q <= `UMB_RST_QUEUE;
      filling_queue_index_q <= `UMB_RST_QUEUE;
      queue_byte_pointer_q <= `UMB_LOC_ZERO;
      receive_read_pointer_q <= `UMB_RST_RD_PTR;
      receive_write_pointer_q <= `UMB_RST_WR_PTR;
      oldest_unread_message_pointer_q <= `UMB_RST_NXT_PTR;
      free_space_q <= `UMB_RST_SPACE;
      rdata_q <= 8'h00;
      txq_wr_en_q <= 1'b0;
      txq_wr_queue_q <= `UMB_RST_QUEUE;
      txq_wr_loc_q <= `UMB_LOC_ZERO;
      txq_wr_data_q <= 8'h00;
    end else begin
      cmd_addr_q <= cmd_addr_d;
      send_queue_q <= UART_SEND_QUEUE;
      filling_queue_index_q <= filling_queue_index_d;
      queue_byte_pointer_q <= queue_byte_pointer_d;
      receive_read_pointer_q <= receive_read_pointer_d;
      receive_write_pointer_q <= receive_write_pointer_d;
      oldest_unread_message_pointer_q <= oldest_unread_message_pointer_d;
      free_space_q <= free_space_d;
      rdata_q <= rdata_d;
      txq_wr_en_q <= txq_wr_en_d;
      txq_wr_queue_q <= filling_queue_index_q;
      txq_wr_loc_q <= txq_wr_loc_d;
      txq_wr_data_q <= txq_wr_data_d;
    end
  end

  // Registered outputs
  assign HOST_RDATA = rdata_q;
  assign TXQ_WR_EN = txq_wr_en_q;
  assign TXQ_WR_QUEUE = txq_wr_queue_q;
  assign TXQ_WR_LOC = txq_wr_loc_q;
  assign TXQ_WR_DATA = txq_wr_data_q;

endmodule // umb_pointers

`default_nettype wire

// ===== umb_consts.vh
/*
  Constants for the message buffer pointer block: register offsets,
  field positions, reset values and buffer limits.
  Assumes it is included by bare name from the design files.
*/
`ifndef UMB_CONSTS_VH
`define UMB_CONSTS_VH

// Register write offsets; the read address is the offset with bit 0 set
`define UMB_OFS_TXQ_SEL 8'h94
`define UMB_OFS_RD_POINTER 8'h96
`define UMB_OFS_WR_POINTER 8'h98
`define UMB_OFS_RX_NXT_PTR 8'h9a
`define UMB_OFS_FREE_SPACE 8'h9c
`define UMB_OFS_RX_FLAGS 8'h9e
`define UMB_OFS_ADV_LOAD 8'hb0
`define UMB_OFS_RX_MSG 8'h90
`define UMB_OFS_RX_NXT_MSG 8'h92

// Field positions
`define UMB_TXQ_SEND_HI 3
`define UMB_TXQ_SEND_LO 2
`define UMB_TXQ_LOAD_HI 1
`define UMB_TXQ_LOAD_LO 0
`define UMB_FLAG_FIRST 2
`define UMB_FLAG_ERR 1
`define UMB_FLAG_LAST 0

// Reset values
`define UMB_RST_RD_PTR 7'h00
`define UMB_RST_WR_PTR 7'h01
`define UMB_RST_NXT_PTR 7'h00
`define UMB_RST_SPACE 7'h56
`define UMB_RST_QUEUE 2'h0

// Transmit queue location limits
`define UMB_LOC_LAST 5'h1e
`define UMB_LOC_ZERO 5'h00

`endif

// ===== umb_rx_store.v
/*
  Receive buffer storage: one entry per location holding the data byte
  and its first, error and last flags, one write port, one read port.
  Assumes a single clock shared with the pointer logic.
*/
`default_nettype none

module umb_rx_store #(
  parameter AW = 7,
  parameter DW = 11
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  // Read port
  input wire [AW-1:0] rd_addr,
  output wire [DW-1:0] rd_data
);

  localparam DEPTH = 1 << AW;

  reg [DW-1:0] mem_q [0:DEPTH-1];

  genvar g;

  // Flip-flop storage, cleared so reads are defined after reset
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          mem_q[g] <= {DW{1'b0}};
        end else if (wr_en && (wr_addr == g)) begin
          mem_q[g] <= wr_data;
        end
      end
    end
  endgenerate

  // Asynchronous read at the given index
  assign rd_data = mem_q[rd_addr];

endmodule // umb_rx_store

`default_nettype wire

// ===== umb_pointers_assertions.sv
/* Checker for the message buffer pointer block.
   Assumes the bind below and the single CLK domain. */
`default_nettype none
module umb_pointers_assertions (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Host side
  input wire logic HOST_CMD,
  input wire logic [7:0] HOST_ADDR,
  input wire logic HOST_WR,
  input wire logic [7:0] HOST_WDATA,
  input wire logic HOST_RD,
  input wire logic [7:0] HOST_RDATA,
  // UART side
  input wire logic UART_WR_READY,
  input wire logic [1:0] UART_SEND_QUEUE,
  // Queue writes
  input wire logic TXQ_WR_EN,
  input wire logic [1:0] TXQ_WR_QUEUE,
  input wire logic [4:0] TXQ_WR_LOC,
  input wire logic [7:0] TXQ_WR_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  chk_load_data: assert property (
    TXQ_WR_EN |-> $past(HOST_WR) && TXQ_WR_DATA == $past(HOST_WDATA))
    else $error("queue write without matching host byte");
  chk_loc_limit: assert property (TXQ_WR_EN |-> TXQ_WR_LOC <= 5'h1e)
    else $error("queue write past location 30");
  chk_first_loc: assert property (
    (HOST_CMD && HOST_ADDR == 8'hb0) ##1 HOST_WR |=> TXQ_WR_EN && TXQ_WR_LOC == 5'h00)
    else $error("first burst byte not at location zero");
  chk_loc_step: assert property (
    TXQ_WR_EN ##1 TXQ_WR_EN |-> TXQ_WR_LOC == $past(TXQ_WR_LOC) + 5'h01
      && $stable(TXQ_WR_QUEUE))
    else $error("burst location or queue wrong");
  chk_loc_stop: assert property (
    TXQ_WR_EN && TXQ_WR_LOC == 5'h1e && HOST_WR |=> !TXQ_WR_EN)
    else $error("byte beyond location 30 written");
  chk_rdata_hold: assert property (!HOST_RD |=> $stable(HOST_RDATA))
    else $error("read data moved without a read");
  chk_send_index: assert property (
    (HOST_CMD && HOST_ADDR == 8'h95) ##2 HOST_RD
      |=> HOST_RDATA[3:2] == $past(UART_SEND_QUEUE, 2))
    else $error("sending queue index wrong");
  chk_ready_space: assert property (
    (HOST_CMD && HOST_ADDR == 8'h9d) ##2 HOST_RD
      |=> UART_WR_READY == (HOST_RDATA != 8'h00))
    else $error("store ready disagrees with free count");
endmodule // umb_pointers_assertions

bind umb_pointers umb_pointers_assertions umb_pointers_assertions_inst (.CLK, .RST,
  .HOST_CMD, .HOST_ADDR, .HOST_WR, .HOST_WDATA, .HOST_RD, .HOST_RDATA, .UART_WR_READY,
  .UART_SEND_QUEUE, .TXQ_WR_EN, .TXQ_WR_QUEUE, .TXQ_WR_LOC, .TXQ_WR_DATA);
`default_nettype wire

// ===== umb_host_model.sv
/* Host model: issues command bytes, burst writes and reads.
   Assumes it changes strobes at the falling edge of clk. */
`default_nettype none
module umb_host_model (
  // Clock and read data
  input wire logic clk,
  input wire logic [7:0] rdata,
  // Host strobes
  output logic cmd,
  output logic [7:0] addr,
  output logic wr,
  output logic [7:0] wdata,
  output logic rd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus
  initial begin
    {cmd, wr, rd} = 3'b000;
    addr = 8'h00;
    wdata = 8'h00;
  end
  task burst(input logic [7:0] a, input int n, input logic [7:0] d0);
    @(negedge clk);
    cmd = 1'b1;
    addr = a;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      cmd = 1'b0;
      addr = ~a;
      wr = 1'b1;
      wdata = d0 + 8'(i);
    end
    @(negedge clk);
    {cmd, wr} = 2'b00;
    addr = ~a;
    wdata = ~wdata;
  endtask
  // Command then one read byte
  task rreg(input logic [7:0] a, output logic [7:0] d);
    burst(a, 0, 8'h00);
    @(negedge clk);
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask
endmodule // umb_host_model
`default_nettype wire

// ===== umb_pointers_tb.sv
/* Testbench for the message buffer pointer block.
   Assumes the host model and the bound checker. */
`default_nettype none
module umb_pointers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RST, HOST_CMD, HOST_WR, HOST_RD, UART_WR, UART_FIRST, UART_ERR, UART_LAST;
  logic [7:0] HOST_ADDR, HOST_WDATA, HOST_RDATA, UART_DATA, TXQ_WR_DATA, d, last_data;
  logic [1:0] UART_SEND_QUEUE, TXQ_WR_QUEUE, last_q;
  logic [4:0] TXQ_WR_LOC, last_loc;
  logic UART_WR_READY, TXQ_WR_EN;
  int n_mismatch = 0, total_checks = 0, n_tx = 0, b;
  umb_pointers umb_pointers_inst (.CLK, .RST, .HOST_CMD, .HOST_ADDR, .HOST_WR, .HOST_WDATA,
    .HOST_RD, .HOST_RDATA, .UART_WR, .UART_DATA, .UART_FIRST, .UART_ERR, .UART_LAST,
    .UART_WR_READY, .UART_SEND_QUEUE, .TXQ_WR_EN, .TXQ_WR_QUEUE, .TXQ_WR_LOC, .TXQ_WR_DATA);
  umb_host_model umb_host_model_inst (.clk(CLK), .rdata(HOST_RDATA), .cmd(HOST_CMD),
    .addr(HOST_ADDR), .wr(HOST_WR), .wdata(HOST_WDATA), .rd(HOST_RD));
  // Tally queue writes
  always @(posedge CLK) begin
    if (TXQ_WR_EN === 1'b1) begin
      n_tx <= n_tx + 1;
      last_loc <= TXQ_WR_LOC;
      last_q <= TXQ_WR_QUEUE;
      last_data <= TXQ_WR_DATA;
    end
  end
  task check(input logic [7:0] seen, input logic [7:0] ev);
    total_checks++;
    if (seen !== ev) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, ev);
    end
  endtask
  task close_out;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One received byte with its flags
  task store(input logic [7:0] dv, input logic [2:0] fl);
    @(negedge CLK);
    UART_WR = 1'b1;
    UART_DATA = dv;
    {UART_FIRST, UART_ERR, UART_LAST} = fl;
    @(negedge CLK);
    UART_WR = 1'b0;
    UART_DATA = ~dv;
  endtask
  // Register values after reset
  task automatic t_reset;
    logic [7:0] ofs [6] = '{8'h95, 8'h97, 8'h99, 8'h9b, 8'h9d, 8'h9f};
    logic [7:0] ev [6] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h56, 8'h00};
    for (int i = 0; i < 6; i++) begin
      umb_host_model_inst.rreg(ofs[i], d);
      check(d, ev[i]);
    end
    check({7'h00, UART_WR_READY}, 8'h01);
  endtask
  // Empty advances with wrap, then an overlong burst
  task t_queue;
    for (int i = 1; i <= 4; i++) begin
      UART_SEND_QUEUE = 2'(4 - i);
      umb_host_model_inst.burst(8'hb0, 0, 8'h00);
      umb_host_model_inst.rreg(8'h95, d);
      check(d, {4'h0, 2'(4 - i), 2'(i)});
    end
    b = n_tx;
    umb_host_model_inst.burst(8'hb0, 32, 8'h40);
    @(negedge CLK);
    check(8'(n_tx - b), 8'h1f);
    check({3'h0, last_loc}, 8'h1e);
    check({6'h0, last_q}, 8'h01);
    check(last_data, 8'h5e);
  endtask
  // Store a message, walk it, then jump to the next one
  task automatic t_rx;
    logic [7:0] ofs [12] = '{8'h99, 8'h9d, 8'h91, 8'h9f, 8'h91, 8'h9f, 8'h91, 8'h9f,
      8'h91, 8'h97, 8'h9b, 8'h9d};
    logic [7:0] ev [12] = '{8'h04, 8'h53, 8'h00, 8'h04, 8'h11, 8'h02, 8'h22, 8'h01,
      8'h00, 8'h03, 8'h04, 8'h57};
    store(8'h11, 3'b100);
    store(8'h22, 3'b010);
    store(8'h00, 3'b001);
    for (int i = 0; i < 12; i++) begin
      umb_host_model_inst.rreg(ofs[i], d);
      if (i != 2)
        check(d, ev[i]);
    end
    umb_host_model_inst.rreg(8'h93, d);
    umb_host_model_inst.rreg(8'h97, d);
    check(d, 8'h04);
  endtask
  // Clock
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // Main sequence
  initial begin
    RST = 1'b1;
    {UART_WR, UART_FIRST, UART_ERR, UART_LAST} = 4'h0;
    UART_DATA = 8'h00;
    UART_SEND_QUEUE = 2'h0;
    repeat (10) @(negedge CLK);
    RST = 1'b0;
    t_reset;
    t_queue;
    t_rx;
    close_out;
  end
  // Watchdog
  initial begin
    #200000;
    n_mismatch++;
    close_out;
  end
endmodule // umb_pointers_tb
`default_nettype wire
